// ---- src/pcw_pkg.sv ----
// Constants and carrier types for the PWM channel waveform timer
package pcw_pkg;

  // -------------------------------------------------------------------------
  // Register map
  // -------------------------------------------------------------------------
  localparam int          ADDR_W           = 8;
  localparam logic [2:0]  BANK_CTRL        = 3'h0;
  localparam logic [2:0]  BANK_COUNTER     = 3'h1;
  localparam logic [2:0]  BANK_PERIOD      = 3'h2;
  localparam logic [2:0]  BANK_DUTY        = 3'h3;
  localparam logic [2:0]  BANK_WIDE_CNT    = 3'h4;
  localparam logic [2:0]  IDX_ENABLE       = 3'h0;
  localparam logic [2:0]  IDX_POLARITY     = 3'h1;
  localparam logic [2:0]  IDX_CLOCK_SEL    = 3'h2;
  localparam logic [2:0]  IDX_ALIGNMENT    = 3'h3;
  localparam logic [2:0]  IDX_CONCAT       = 3'h4;
  localparam int          BANK_LSB         = 5;
  localparam int          IDX_LSB          = 2;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // -------------------------------------------------------------------------
  // Reset values
  // -------------------------------------------------------------------------
  localparam logic [7:0]  RST_CTRL         = 8'h00;
  localparam logic [3:0]  RST_CONCAT       = 4'h0;
  localparam logic [7:0]  RST_BYTE         = 8'h00;
  localparam logic [7:0]  RST_UP           = 8'hff;

  // -------------------------------------------------------------------------
  // Carriers
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } pcw_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pcw_axi_rsp_type;

  typedef struct packed {
    logic [15:0] cnt;
    logic        up;
    logic        ff;
    logic        load;
  } pcw_step_type;

  // Prescaled tick strobes, index = {scaled, group B}
  typedef struct packed {
    logic sb;
    logic sa;
    logic b;
    logic a;
  } pcw_ticks_type;

endpackage

// ---- src/pcw_timer.sv ----
// Eight-channel waveform timer with pairwise joining and an AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none
module pcw_timer
  import pcw_pkg::*;
(
  input  wire logic            clk,       // 50 MHz system clock
  input  wire logic            sys_rst,   // Asynchronous reset, active high
  input  wire logic            ce,        // Clock enable, freezes all state
  input  wire pcw_ticks_type   ticks,     // Prescaled clock strobes, same domain
  input  wire pcw_axi_req_type axiReq,    // AXI4-Lite master side
  output var  pcw_axi_rsp_type axiRsp,    // AXI4-Lite slave answers
  output var  logic [7:0]      waveOut,   // Channel waveform levels
  output var  logic [7:0]      waveOe     // Channel pin drive enables
);

  // -------------------------------------------------------------------------
  // Helper functions
  // -------------------------------------------------------------------------
  // One count step of a channel; 8-bit channels pass zero high bytes
  function automatic pcw_step_type pcw_step(input logic [15:0] cnt,
                                            input logic [15:0] per,
                                            input logic [15:0] dty,
                                            input logic        up,
                                            input logic        ff,
                                            input logic        center);
    pcw_step_type r;
    logic [16:0]  inc;
    logic [15:0]  dn;
    r.cnt  = cnt;
    r.up   = up;
    r.ff   = ff;
    r.load = 1'b0;
    inc    = {1'b0, cnt} + 17'h00001;
    dn     = cnt - 16'h0001;
    if (!center) begin
      if (inc >= {1'b0, per}) begin
        r.cnt  = 16'h0000;
        r.ff   = 1'b0;
        r.load = 1'b1;
      end else begin
        r.cnt = inc[15:0];
        if (inc[15:0] == dty) r.ff = ~ff;
      end
    end else if (up || cnt == 16'h0000) begin
      r.up = 1'b1;
      if (per == 16'h0000) begin
        r.cnt  = 16'h0000;
        r.load = 1'b1;
      end else if (cnt >= per && cnt != 16'h0000) begin
        r.up  = 1'b0;
        r.cnt = dn;
        if (dn == dty) r.ff = ~ff;
      end else begin
        r.cnt = inc[15:0];
        if (inc[15:0] == dty) r.ff = ~ff;
      end
    end else begin
      r.cnt = dn;
      if (dn == dty) r.ff = ~ff;
      if (dn == 16'h0000) begin
        r.up   = 1'b1;
        r.ff   = 1'b0;
        r.load = 1'b1;
      end
    end
    return r;
  endfunction

  // Pin level from boundary cases, then flop and polarity
  function automatic logic pcw_level(input logic [15:0] per,
                                     input logic [15:0] dty,
                                     input logic        ff,
                                     input logic        pol);
    if (per == 16'h0000) return pol;
    if (dty == 16'h0000) return ~pol;
    if (dty >= per)      return pol;
    return ff ^ pol;
  endfunction

  // Channels 0,1,4,5 use A/SA, channels 2,3,6,7 use B/SB
  function automatic logic pcw_tick(input logic [2:0]    ch,
                                    input logic          scaled,
                                    input pcw_ticks_type t);
    logic [3:0] v;
    v = t;
    return v[{scaled, ch[1]}];
  endfunction

  function automatic logic pcw_addr_ok(input logic [ADDR_W-1:0] a);
    logic [2:0] bank;
    logic [2:0] idx;
    bank = a[BANK_LSB+:3];
    idx  = a[IDX_LSB+:3];
    case (bank)
      BANK_CTRL:     return idx <= IDX_CONCAT;
      BANK_COUNTER,
      BANK_PERIOD,
      BANK_DUTY:     return 1'b1;
      BANK_WIDE_CNT: return idx < 3'h4;
      default:       return 1'b0;
    endcase
  endfunction

  // -------------------------------------------------------------------------
  // Register and channel state
  // -------------------------------------------------------------------------
  logic [7:0]   enable_r;                      // Channel enable bits
  logic [7:0]   polarity_r;                    // Polarity select bits
  logic [7:0]   clkSel_r;                      // Scaled clock select bits
  logic [7:0]   align_r;                       // Centre alignment select bits
  logic [3:0]   concat_r;                      // Pair join bits, bit p joins 2p/2p+1
  logic [7:0]   perBuf_r [8];                  // Period buffers written by software
  logic [7:0]   dtyBuf_r [8];                  // Duty buffers written by software
  logic [7:0]   perAct_r [8];                  // Active periods
  logic [7:0]   dtyAct_r [8];                  // Active duties
  logic [7:0]   cnt_r    [8];                  // Channel counters
  logic [7:0]   up_r;                          // Count direction, 1 is up
  logic [7:0]   ff_r;                          // Output flip-flops
  logic [7:0]   tick;
  logic [7:0]   cntWr;
  pcw_step_type s8  [8];
  pcw_step_type s16 [4];

  // -------------------------------------------------------------------------
  // AXI4-Lite slave
  // -------------------------------------------------------------------------
  logic              awHave_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic              wHave_r;
  logic [31:0]       wData_r;
  logic [3:0]        wStrb_r;
  logic              bValid_r;
  logic [1:0]        bResp_r;
  logic              rValid_r;
  logic [31:0]       rData_r;
  logic [1:0]        rResp_r;
  logic              doWrite;
  logic [2:0]        wrBank;
  logic [2:0]        wrIdx;
  logic [31:0]       rdWord;

  // Handshakes drop while frozen so nothing is taken unseen
  always_comb begin
    axiRsp.awready = ce & ~awHave_r;
    axiRsp.wready  = ce & ~wHave_r;
    axiRsp.bvalid  = bValid_r;
    axiRsp.bresp   = bResp_r;
    axiRsp.arready = ce & ~rValid_r;
    axiRsp.rvalid  = rValid_r;
    axiRsp.rdata   = rData_r;
    axiRsp.rresp   = rResp_r;
  end

  assign doWrite = ce & awHave_r & wHave_r & ~bValid_r;
  assign wrBank  = awAddr_r[BANK_LSB+:3];
  assign wrIdx   = awAddr_r[IDX_LSB+:3];

  // Address and data are caught independently, in either order
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHave_r <= 1'b0;
      awAddr_r <= '0;
      wHave_r  <= 1'b0;
      wData_r  <= 32'h00000000;
      wStrb_r  <= 4'h0;
    end else if (ce) begin
      if (axiReq.awvalid && !awHave_r) begin
        awHave_r <= 1'b1;
        awAddr_r <= axiReq.awaddr;
      end else if (doWrite) begin
        awHave_r <= 1'b0;
      end
      if (axiReq.wvalid && !wHave_r) begin
        wHave_r <= 1'b1;
        wData_r <= axiReq.wdata;
        wStrb_r <= axiReq.wstrb;
      end else if (doWrite) begin
        wHave_r <= 1'b0;
      end
    end
  end

  // Write response, unmapped addresses answer SLVERR
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bValid_r <= 1'b0;
      bResp_r  <= RESP_OKAY;
    end else if (ce) begin
      if (doWrite) begin
        bValid_r <= 1'b1;
        bResp_r  <= pcw_addr_ok(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (axiReq.bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  // Read mux; the wide counter view gives a coherent joined count
  always_comb begin
    logic [2:0] bank;
    logic [2:0] idx;
    bank   = axiReq.araddr[BANK_LSB+:3];
    idx    = axiReq.araddr[IDX_LSB+:3];
    rdWord = 32'h00000000;
    case (bank)
      BANK_CTRL: begin
        case (idx)
          IDX_ENABLE:    rdWord[7:0] = enable_r;
          IDX_POLARITY:  rdWord[7:0] = polarity_r;
          IDX_CLOCK_SEL: rdWord[7:0] = clkSel_r;
          IDX_ALIGNMENT: rdWord[7:0] = align_r;
          IDX_CONCAT:    rdWord[3:0] = concat_r;
          default:       rdWord      = 32'h00000000;
        endcase
      end
      BANK_COUNTER:  rdWord[7:0]  = cnt_r[idx];
      BANK_PERIOD:   rdWord[7:0]  = perBuf_r[idx];
      BANK_DUTY:     rdWord[7:0]  = dtyBuf_r[idx];
      BANK_WIDE_CNT: rdWord[15:0] = {cnt_r[{idx[1:0], 1'b0}], cnt_r[{idx[1:0], 1'b1}]};
      default:       rdWord       = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rValid_r <= 1'b0;
      rData_r  <= 32'h00000000;
      rResp_r  <= RESP_OKAY;
    end else if (ce) begin
      if (axiReq.arvalid && !rValid_r) begin
        rValid_r <= 1'b1;
        rData_r  <= pcw_addr_ok(axiReq.araddr) ? rdWord : 32'h00000000;
        rResp_r  <= pcw_addr_ok(axiReq.araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (axiReq.rready) begin
        rValid_r <= 1'b0;
      end
    end
  end

  // Control and buffer registers, written only with lane 0 strobed
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_r   <= RST_CTRL;
      polarity_r <= RST_CTRL;
      clkSel_r   <= RST_CTRL;
      align_r    <= RST_CTRL;
      concat_r   <= RST_CONCAT;
      for (int c = 0; c < 8; c++) begin
        perBuf_r[c] <= RST_BYTE;
        dtyBuf_r[c] <= RST_BYTE;
      end
    end else if (ce && doWrite && wStrb_r[0]) begin
      case (wrBank)
        BANK_CTRL: begin
          case (wrIdx)
            IDX_ENABLE:    enable_r   <= wData_r[7:0];
            IDX_POLARITY:  polarity_r <= wData_r[7:0];
            IDX_CLOCK_SEL: clkSel_r   <= wData_r[7:0];
            IDX_ALIGNMENT: align_r    <= wData_r[7:0];
            IDX_CONCAT:    concat_r   <= wData_r[3:0];
            default:       ;
          endcase
        end
        BANK_PERIOD: perBuf_r[wrIdx] <= wData_r[7:0];
        BANK_DUTY:   dtyBuf_r[wrIdx] <= wData_r[7:0];
        default:     ;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Channel engines
  // -------------------------------------------------------------------------
  // Counter writes clear regardless of byte strobes
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      cntWr[c] = doWrite && wrBank == BANK_COUNTER && wrIdx == 3'(c);
      tick[c]  = pcw_tick(3'(c), clkSel_r[c], ticks);
      s8[c]    = pcw_step({8'h00, cnt_r[c]}, {8'h00, perAct_r[c]}, {8'h00, dtyAct_r[c]},
                          up_r[c], ff_r[c], align_r[c]);
    end
    // Joined pairs: even bytes high, odd controls rule
    for (int p = 0; p < 4; p++) begin
      s16[p] = pcw_step({cnt_r[2*p], cnt_r[2*p+1]},
                        {perAct_r[2*p], perAct_r[2*p+1]},
                        {dtyAct_r[2*p], dtyAct_r[2*p+1]},
                        up_r[2*p+1], ff_r[2*p+1], align_r[2*p+1]);
    end
  end

  // Counters, direction, flops and active period/duty
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      up_r <= RST_UP;
      ff_r <= RST_CTRL;
      for (int c = 0; c < 8; c++) begin
        cnt_r[c]    <= RST_BYTE;
        perAct_r[c] <= RST_BYTE;
        dtyAct_r[c] <= RST_BYTE;
      end
    end else if (ce) begin
      for (int p = 0; p < 4; p++) begin
        if (concat_r[p]) begin
          up_r[2*p] <= 1'b1;
          ff_r[2*p] <= 1'b0;
          if (cntWr[2*p] || cntWr[2*p+1]) begin
            cnt_r[2*p]      <= RST_BYTE;
            cnt_r[2*p+1]    <= RST_BYTE;
            up_r[2*p+1]     <= 1'b1;
            ff_r[2*p+1]     <= 1'b0;
          end else if (enable_r[2*p+1] && tick[2*p+1]) begin
            cnt_r[2*p]      <= s16[p].cnt[15:8];
            cnt_r[2*p+1]    <= s16[p].cnt[7:0];
            up_r[2*p+1]     <= s16[p].up;
            ff_r[2*p+1]     <= s16[p].ff;
          end
          // Reload on period end, counter write or while disabled
          if (cntWr[2*p] || cntWr[2*p+1] || !enable_r[2*p+1]
              || (tick[2*p+1] && s16[p].load)) begin
            perAct_r[2*p]   <= perBuf_r[2*p];
            perAct_r[2*p+1] <= perBuf_r[2*p+1];
            dtyAct_r[2*p]   <= dtyBuf_r[2*p];
            dtyAct_r[2*p+1] <= dtyBuf_r[2*p+1];
          end
        end else begin
          for (int j = 0; j < 2; j++) begin
            if (cntWr[2*p+j]) begin
              cnt_r[2*p+j] <= RST_BYTE;
              up_r[2*p+j]  <= 1'b1;
              ff_r[2*p+j]  <= 1'b0;
            end else if (enable_r[2*p+j] && tick[2*p+j]) begin
              cnt_r[2*p+j] <= s8[2*p+j].cnt[7:0];
              up_r[2*p+j]  <= s8[2*p+j].up;
              ff_r[2*p+j]  <= s8[2*p+j].ff;
            end
            if (cntWr[2*p+j] || !enable_r[2*p+j]
                || (tick[2*p+j] && s8[2*p+j].load)) begin
              perAct_r[2*p+j] <= perBuf_r[2*p+j];
              dtyAct_r[2*p+j] <= dtyBuf_r[2*p+j];
            end
          end
        end
      end
    end
  end

  // Registered pin levels; a disabled or joined high channel is held low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      waveOut <= RST_CTRL;
      waveOe  <= RST_CTRL;
    end else if (ce) begin
      for (int p = 0; p < 4; p++) begin
        if (concat_r[p]) begin
          waveOe[2*p]    <= 1'b0;
          waveOut[2*p]   <= 1'b0;
          waveOe[2*p+1]  <= enable_r[2*p+1];
          waveOut[2*p+1] <= enable_r[2*p+1] & pcw_level({perAct_r[2*p], perAct_r[2*p+1]},
                                                        {dtyAct_r[2*p], dtyAct_r[2*p+1]},
                                                        ff_r[2*p+1], polarity_r[2*p+1]);
        end else begin
          for (int j = 0; j < 2; j++) begin
            waveOe[2*p+j]  <= enable_r[2*p+j];
            waveOut[2*p+j] <= enable_r[2*p+j] & pcw_level({8'h00, perAct_r[2*p+j]},
                                                          {8'h00, dtyAct_r[2*p+j]},
                                                          ff_r[2*p+j], polarity_r[2*p+j]);
          end
        end
      end
    end
  end

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  for (genvar g = 0; g < 8; g++) begin : g_chk
    logic fire;
    logic leadTick;
    logic leadEn;
    assign fire = ce & enable_r[g] & tick[g] & ~cntWr[g] & ~concat_r[g/2];
    // A joined pair reloads on its odd channel's clock and enable
    assign leadTick = concat_r[g/2] ? tick[g|1] : tick[g];
    assign leadEn   = concat_r[g/2] ? enable_r[g|1] : enable_r[g];

    sequence sAtTop;
      fire && align_r[g] && up_r[g] && cnt_r[g] != 8'h00 && perAct_r[g] != 8'h00
        && cnt_r[g] >= perAct_r[g];
    endsequence
    sequence sGoingDown;
      !up_r[g] && cnt_r[g] == $past(cnt_r[g]) - 8'h01;
    endsequence

    a_left_wrap: assert property (fire && !align_r[g]
        && ({1'b0, cnt_r[g]} + 9'h001) >= {1'b0, perAct_r[g]}
        |=> cnt_r[g] == 8'h00 && !ff_r[g])
      else $error("left counter did not wrap at period");
    a_left_count: assert property (fire && !align_r[g]
        && ({1'b0, cnt_r[g]} + 9'h001) < {1'b0, perAct_r[g]}
        |=> cnt_r[g] == $past(cnt_r[g]) + 8'h01)
      else $error("left counter did not count up");
    a_center_turn: assert property (sAtTop |=> sGoingDown)
      else $error("centre counter did not turn at period");
    a_center_reload: assert property (fire && align_r[g] && !up_r[g] && cnt_r[g] == 8'h01
        |=> up_r[g] && cnt_r[g] == 8'h00 && perAct_r[g] == $past(perBuf_r[g]))
      else $error("centre zero did not reload and turn up");
    a_count_clear: assert property (ce && cntWr[g]
        |=> cnt_r[g] == 8'h00 && up_r[g])
      else $error("counter write did not clear counter");
    a_zero_period: assert property (ce && enable_r[g] && !concat_r[g/2] && perAct_r[g] == 8'h00
        |=> waveOut[g] == $past(polarity_r[g]))
      else $error("zero period level wrong");
    a_buffer_hold: assert property (ce && leadEn && !leadTick && cntWr == 8'h00
        && $stable(enable_r) |=> $stable(perAct_r[g]) && $stable(dtyAct_r[g]))
      else $error("active period changed without reload event");
    a_idle_hold: assert property (ce && !enable_r[g] && !concat_r[g/2] && !cntWr[g]
        |=> $stable(cnt_r[g]))
      else $error("disabled counter moved");

    if (g % 2 == 0) begin : g_even
      a_high_off: assert property (ce && concat_r[g/2] |=> !waveOe[g])
        else $error("joined high channel output not disabled");
    end else begin : g_odd
      a_wide_wrap: assert property (ce && concat_r[g/2] && enable_r[g] && tick[g]
          && !cntWr[g] && !cntWr[g-1] && !align_r[g]
          && ({1'b0, cnt_r[g-1], cnt_r[g]} + 17'h00001) >= {1'b0, perAct_r[g-1], perAct_r[g]}
          |=> cnt_r[g-1] == 8'h00 && cnt_r[g] == 8'h00)
        else $error("joined counter did not wrap on full period");
    end
  end

endmodule
`default_nettype wire

// ---- testbench/pcw_pin_load.sv ----
// Load model standing on the channel output pins
`timescale 1ns/100ps
`default_nettype none
module pcw_pin_load (
  input  wire logic [7:0] waveOut,  // Levels from the timer
  input  wire logic [7:0] waveOe,   // Drive enables from the timer
  output var  logic [7:0] pinLevel  // Level seen at each load
);
  // Pull-down on every pin, so a released pin reads low
  assign pinLevel = waveOut & waveOe;
endmodule
`default_nettype wire

// ---- testbench/pwm_channel_waveform_timer_tb_top.sv ----
// Self-checking bench for the waveform timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module pwm_channel_waveform_timer_tb_top;
  import pcw_pkg::*;
  logic            clk;
  logic            sys_rst;
  logic            ce;
  pcw_ticks_type   ticks;
  pcw_axi_req_type axiReq;
  pcw_axi_rsp_type axiRsp;
  logic [7:0]      waveOut;
  logic [7:0]      waveOe;
  logic [7:0]      pinLevel;
  int              mismatches;
  int              nTests;
  int              cyc;
  // ---------------------------------------------------------------
  // Clock, instances, timeout
  // ---------------------------------------------------------------
  initial clk = 1'b0;
  always #10 clk = ~clk;
  pcw_timer dut_u (.clk(clk), .sys_rst(sys_rst), .ce(ce), .ticks(ticks), .axiReq(axiReq),
                   .axiRsp(axiRsp), .waveOut(waveOut), .waveOe(waveOe));
  pcw_pin_load load_u (.waveOut(waveOut), .waveOe(waveOe), .pinLevel(pinLevel));
  // Whole run needs about 1300 cycles; ceiling leaves ample margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Bus cycles and measurement
  // ---------------------------------------------------------------
  // Each channel is released only after the edge that took it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aT, wT, ah, wh, b;
    logic [1:0] r;
    ah = 1'b0;
    wh = 1'b0;
    b = 1'b0;
    @(posedge clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hf;
    axiReq.bready <= 1'b1;
    while (!(ah && wh)) begin
      @(negedge clk);
      aT = axiReq.awvalid & axiRsp.awready;
      wT = axiReq.wvalid & axiRsp.wready;
      @(posedge clk);
      if (aT) axiReq.awvalid <= 1'b0;
      if (wT) axiReq.wvalid <= 1'b0;
      ah |= aT;
      wh |= wT;
    end
    while (!b) begin
      @(negedge clk);
      b = axiRsp.bvalid;
      r = axiRsp.bresp;
      @(posedge clk);
    end
    axiReq.bready <= 1'b0;
    `CHK("bresp", RESP_OKAY, r)
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    t = 1'b0;
    @(posedge clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    while (!t) begin
      @(negedge clk);
      t = axiReq.arvalid & axiRsp.arready;
      @(posedge clk);
    end
    axiReq.arvalid <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge clk);
      t = axiRsp.rvalid;
      d = axiRsp.rdata;
      r = axiRsp.rresp;
      @(posedge clk);
    end
    axiReq.rready <= 1'b0;
  endtask
  // Loads period and duty, then a counter write forces them active
  task automatic setup(input logic [2:0] ch, input logic [7:0] per, input logic [7:0] dty);
    wr(8'h40 | {3'h0, ch, 2'h0}, {24'h0, per});
    wr(8'h60 | {3'h0, ch, 2'h0}, {24'h0, dty});
    wr(8'h20 | {3'h0, ch, 2'h0}, 32'h0);
  endtask
  // Counts high samples and rising edges over whole periods
  task automatic measure(input int ch, input int n, input int hi, input int rise);
    logic [15:0] h, r;
    logic p;
    h = 0;
    r = 0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    p = pinLevel[ch];
    repeat (n) begin
      @(negedge clk);
      h += pinLevel[ch];
      r += pinLevel[ch] & !p;
      p = pinLevel[ch];
    end
    `CHK("highCount", hi, h)
    `CHK("riseCount", rise, r)
  endtask
  // Pins must not move for eight cycles; an unknown level fails too
  task automatic hold_check(input string nm);
    logic [7:0] w, d;
    @(negedge clk);
    w = waveOut;
    d = 8'h00;
    repeat (8) begin
      @(negedge clk);
      d |= w ^ waveOut;
    end
    `CHK(nm, 8'h00, d)
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    @(negedge clk);
    `CHK("waveOe", 8'h00, waveOe)
    `CHK("waveOut", 8'h00, waveOut)
    rd(8'h00, d, r);
    `CHK("enableReg", 32'h0, d)
    rd(8'h20, d, r);
    `CHK("idleCounter", 32'h0, d)
    rd(8'hfc, d, r);
    `CHK("unmappedResp", RESP_SLVERR, r)
  endtask
  task automatic t_left();
    setup(0, 8'h04, 8'h01);
    wr(8'h00, 32'h1);
    measure(0, 40, 30, 10);
    wr(8'h40, 32'h8);
    measure(0, 80, 70, 10);
    wr(8'h04, 32'h1);
    wr(8'h20, 32'h0);
    measure(0, 64, 8, 8);
    // Clock enable low freezes the pins and refuses bus requests
    @(posedge clk);
    ce <= 1'b0;
    hold_check("frozenWave");
    `CHK("frozenReady", 1'b0, axiRsp.awready)
    @(posedge clk);
    ce <= 1'b1;
    // Stopped on an idle scaled clock: a new duty stays buffered
    wr(8'h08, 32'h1);
    wr(8'h60, 32'h0);
    hold_check("stoppedWave");
    wr(8'h08, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h0);
  endtask
  task automatic t_centre();
    wr(8'h0c, 32'h4);
    setup(2, 8'h04, 8'h01);
    wr(8'h00, 32'h4);
    measure(2, 80, 60, 10);
    wr(8'h00, 32'h0);
    wr(8'h0c, 32'h0);
  endtask
  task automatic t_bound();
    wr(8'h00, 32'h1);
    setup(0, 8'h04, 8'h00);
    measure(0, 40, 40, 0);
    setup(0, 8'h04, 8'h05);
    measure(0, 40, 0, 0);
    setup(0, 8'h00, 8'h02);
    measure(0, 40, 0, 0);
    wr(8'h04, 32'h1);
    setup(0, 8'h04, 8'h04);
    measure(0, 40, 40, 0);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h0);
  endtask
  task automatic t_join();
    logic [31:0] d;
    logic [31:0] w;
    logic [1:0] r;
    wr(8'h10, 32'h1);
    wr(8'h08, 32'h1);
    setup(0, 8'h01, 8'h00);
    setup(1, 8'h00, 8'h40);
    wr(8'h0c, 32'h1);
    wr(8'h00, 32'h3);
    measure(1, 512, 384, 2);
    `CHK("waveOeJoined", 8'h02, waveOe)
    rd(8'h80, d, r);
    `CHK("wideResp", RESP_OKAY, r)
    `CHK("wideHigh", 8'h00, d[15:8])
    wr(8'h00, 32'h0);
    rd(8'h80, d, r);
    rd(8'h24, w, r);
    `CHK("lowByte", d[7:0], w[7:0])
    wr(8'h20, 32'h0);
    rd(8'h80, d, r);
    `CHK("wideClear", 16'h0000, d[15:0])
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    axiReq = '0;
    ticks = 4'b0011;
    sys_rst = 1'b1;
    ce = 1'b1;
    cyc = 0;
    mismatches = 0;
    nTests = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_left();
    t_centre();
    t_bound();
    t_join();
    stop_test();
  end
endmodule
`default_nettype wire
